// File: hw/wdg_pkg.sv
// window watchdog constants: timing, register map, field layout, states
// assumes a single 125 MHz base clock for the whole watchdog
`default_nettype none
package wdg_pkg;
   // clock and timing
   localparam int CLK_MHZ = 125;
   // one tick is half of the shortest window, so every half-window is whole ticks
   localparam int TICK_TIME_US = 5000;
   localparam int TICK_CYC = TICK_TIME_US * CLK_MHZ;
   localparam int WIN_BASE_MS = 10;
   localparam int INIT_TIMEOUT_MS = 100;
   localparam int TICKS_PER_BASE = WIN_BASE_MS * 1000 / TICK_TIME_US;
   localparam int INIT_TICKS_I = INIT_TIMEOUT_MS * 1000 / TICK_TIME_US;
   localparam int CNT_W = 9;
   localparam int CYC_W = 24;
   localparam logic [CNT_W-1:0] CNT_ONE = 9'h001;
   localparam logic [CNT_W-1:0] CNT_ZERO = 9'h000;
   localparam logic [CNT_W-1:0] INIT_TICKS = CNT_W'(INIT_TICKS_I);
   localparam logic [CNT_W-1:0] BASE_TICKS = CNT_W'(TICKS_PER_BASE);
   // register map, global address space
   localparam int ADDR_W = 16;
   localparam logic [ADDR_W-1:0] BLK_BASE = 16'h0200;
   localparam logic [ADDR_W-1:0] NB_BASE = 16'h0300;
   localparam logic [ADDR_W-1:0] OFS_CONFIG = 16'h0010;
   localparam logic [ADDR_W-1:0] OFS_SERVICE = 16'h0011;
   // config register fields
   localparam int BIT_OFF = 7;
   localparam int BIT_WO = 6;
   localparam int SEL_LSB = 0;
   localparam int SEL_W = 3;
   localparam logic [SEL_W-1:0] SEL_RST = 3'h0;
   localparam logic [2:0] CFG_RSVD = 3'h0;
   localparam logic [7:0] RD_ZERO = 8'h00;
   // service codes
   localparam logic [7:0] SVC_FIRST = 8'hAA;
   localparam logic [7:0] SVC_SECOND = 8'h55;
   localparam logic [7:0] SVC_RST = 8'hAA;
   typedef enum logic [1:0] {ST_OFF, ST_INIT, ST_WINDOW} wdg_state_t;
endpackage
`default_nettype wire

// File: hw/wdg_sync.sv
// two-flop synchroniser for a level from a pin
// assumes the level is slow against clk_sys
`default_nettype none
module wdg_sync (
   input wire logic clk_sys, // base clock
   input wire logic srst, // sync reset, high
   input wire logic din, // asynchronous level
   output logic dout // synchronised level
);
   logic meta_reg;
   logic sync_reg;
   // only sync_reg reads the first stage
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
      end else begin
         meta_reg <= din;
         sync_reg <= meta_reg;
      end
   end
   assign dout = sync_reg;
endmodule
`default_nettype wire

// File: hw/wdg_tick.sv
// prescaler: one-cycle tick every TICK_CYCLES clocks while run is high
// assumes restart comes from logic on clk_sys
`default_nettype none
module wdg_tick import wdg_pkg::*; #(
   parameter int WIDTH = CYC_W,
   parameter int TICK_CYCLES = TICK_CYC
) (
   input wire logic clk_sys, // base clock
   input wire logic srst, // sync reset, high
   input wire logic run, // count enable, low clears the count and stops the tick
   input wire logic restart, // realign the tick phase
   output logic tick // one-cycle pulse
);
   logic [WIDTH-1:0] cyc_reg;
   always_ff @(posedge clk_sys) begin
      if (srst || !run || restart) begin
         cyc_reg <= '0;
         tick <= 1'b0;
      end else if (cyc_reg == WIDTH'(TICK_CYCLES - 1)) begin
         cyc_reg <= '0;
         tick <= 1'b1;
      end else begin
         cyc_reg <= cyc_reg + WIDTH'(1);
         tick <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// File: hw/wdg_core.sv
// window watchdog core with its two registers on the die link register port
// assumes mode inputs come from logic on clk_sys; the test pin level is
// asynchronous and is synchronised here
`default_nettype none
// Operation
// R01 - watchdog runs only in normal mode on its own base clock
// R02 - three-bit select: 10 ms doubling per code up to 1280 ms
// R03 - inactive in low power; stop-mode reads show the off bit set
// R04 - controller alternates service writes, first 0xAA then 0x55
// R05 - after reset a fixed initial timeout runs with window-open set
// R06 - controller writes 0xAA before the initial timeout to enter window mode
// R07 - initial timeout expiry or non-0xAA code gives a watchdog reset
// R08 - first half of window forbids service; service in second half
// R09 - read-only window-open flag shows the window state
// R10 - window expiry or wrong service code forces a watchdog reset
// R11 - expected code while window open clears the counter
// R12 - test pin disable stops the watchdog; off bit shows it
// R13 - disable returns service state to default; restart needs initial sequence
// R14 - service writes while disabled are ignored
// R15 - low power halts the watchdog clock and resets service state
// R16 - config: off bit 7, window-open bit 6, select 2-0, 5-3 zero
// R17 - registers at base 0x0200 blocking and 0x300 non-blocking
// R18 - service write with closed window is a violation and resets
module wdg_core import wdg_pkg::*; #(
   parameter int TICK_CYCLES = TICK_CYC
) (
   input wire logic clk_sys, // base clock
   input wire logic srst, // sync reset, high
   input wire logic normal_mode, // device in normal mode
   input wire logic stop_mode, // device in stop mode
   input wire logic test_disable_voltage, // test pin disable level, async
   input wire logic reg_wr, // register write strobe
   input wire logic reg_rd, // register read strobe
   input wire logic [ADDR_W-1:0] reg_addr, // global register address
   input wire logic [7:0] reg_wdata, // write data
   output logic [7:0] reg_rdata, // read data, one cycle after reg_rd
   output logic reg_rvalid, // read data valid pulse
   output logic wd_reset // watchdog reset pulse
);
   // R17 dual base decode
   function automatic logic addr_hit(input logic [ADDR_W-1:0] a,
                                     input logic [ADDR_W-1:0] ofs);
      addr_hit = (a == BLK_BASE + ofs) || (a == NB_BASE + ofs);
   endfunction

   // R02 window length in ticks
   function automatic logic [CNT_W-1:0] win_full(input logic [SEL_W-1:0] s);
      win_full = BASE_TICKS << s;
   endfunction

   logic dis_sync;
   logic active;
   logic tick;
   logic tick_restart;
   logic svc_wr;
   logic cfg_wr;
   logic cfg_rd;
   logic window_open_flag;
   logic wd_off_flag;
   logic [SEL_W-1:0] timeout_select_reg;
   logic [CNT_W-1:0] full_ticks;
   logic [CNT_W-1:0] half_ticks;
   logic [CNT_W-1:0] cnt_inc;
   wdg_state_t state_reg;
   wdg_state_t state_next;
   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] cnt_next;
   logic [7:0] expect_reg;
   logic [7:0] expect_next;
   logic fault_next;
   logic [7:0] cfg_read;

   wdg_sync u_sync (
      .clk_sys(clk_sys),
      .srst(srst),
      .din(test_disable_voltage),
      .dout(dis_sync)
   );

   // R01 normal mode only
   // R12 pin disable
   // R15 low power halts
   assign active = normal_mode && !dis_sync;

   wdg_tick #(
      .WIDTH(CYC_W),
      .TICK_CYCLES(TICK_CYCLES)
   ) u_tick (
      .clk_sys(clk_sys),
      .srst(srst),
      .run(active),
      .restart(tick_restart),
      .tick(tick)
   );

   // R14 ignore when disabled
   assign svc_wr = reg_wr && addr_hit(reg_addr, OFS_SERVICE) && active;
   assign cfg_wr = reg_wr && addr_hit(reg_addr, OFS_CONFIG);
   assign cfg_rd = reg_rd && addr_hit(reg_addr, OFS_CONFIG);

   assign full_ticks = win_full(timeout_select_reg);
   assign half_ticks = full_ticks >> 1;
   assign cnt_inc = cnt_reg + CNT_ONE;

   // R08 window closed in first half
   // R09 window-open status
   // R05 open during initial period
   always_comb begin
      case (state_reg)
         ST_INIT: window_open_flag = 1'b1;
         ST_WINDOW: window_open_flag = (cnt_reg >= half_ticks);
         default: window_open_flag = 1'b0;
      endcase
   end

   // R03 stop-mode read shows off
   // R12 off indication
   assign wd_off_flag = dis_sync || stop_mode;

   // phase of the tick restarts with each counter clear, so the
   // window edges sit a whole number of ticks after the last service
   assign tick_restart = svc_wr || fault_next || (state_reg == ST_OFF);

   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      expect_next = expect_reg;
      fault_next = 1'b0;
      case (state_reg)
         ST_OFF: begin
            state_next = ST_INIT;
            cnt_next = CNT_ZERO;
            expect_next = SVC_RST;
         end
         ST_INIT: begin
            if (svc_wr) begin
               // R06 first code enters window mode
               if (reg_wdata == SVC_FIRST) begin
                  state_next = ST_WINDOW;
                  cnt_next = CNT_ZERO;
                  expect_next = SVC_SECOND;
               end else begin
                  // R07 wrong initial code
                  fault_next = 1'b1;
               end
            end else if (tick) begin
               // R05 fixed initial timeout
               // R07 initial expiry
               if (cnt_inc == INIT_TICKS) begin
                  fault_next = 1'b1;
               end else begin
                  cnt_next = cnt_inc;
               end
            end
         end
         ST_WINDOW: begin
            if (svc_wr) begin
               // R18 closed-window write
               // R10 wrong code
               if (!window_open_flag || reg_wdata != expect_reg) begin
                  fault_next = 1'b1;
               end else begin
                  // R11 clear counter
                  // R04 alternate expected code
                  cnt_next = CNT_ZERO;
                  expect_next = (expect_reg == SVC_FIRST) ? SVC_SECOND : SVC_FIRST;
               end
            end else if (tick) begin
               // R10 window expiry
               // a select lowered mid-window can leave the count past the new limit;
               // it must still expire instead of running on to wrap
               if (cnt_inc >= full_ticks) begin
                  fault_next = 1'b1;
               end else begin
                  cnt_next = cnt_inc;
               end
            end
         end
         default: begin
            state_next = ST_OFF;
         end
      endcase
      // a reset restarts the initial sequence
      if (fault_next) begin
         state_next = ST_INIT;
         cnt_next = CNT_ZERO;
         expect_next = SVC_RST;
      end
   end

   // R13 default on disable
   // R15 reset in low power
   always_ff @(posedge clk_sys) begin
      if (srst || !active) begin
         state_reg <= ST_OFF;
      end else begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst || !active) begin
         cnt_reg <= CNT_ZERO;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   // R13 service default
   always_ff @(posedge clk_sys) begin
      if (srst || !active) begin
         expect_reg <= SVC_RST;
      end else begin
         expect_reg <= expect_next;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst || !active) begin
         wd_reset <= 1'b0;
      end else begin
         wd_reset <= fault_next;
      end
   end

   // R05 select writable in init
   // the select takes effect on the live window, so a change mid-window
   // moves both edges; software should change it only right after service
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         timeout_select_reg <= SEL_RST;
      end else if (cfg_wr) begin
         timeout_select_reg <= reg_wdata[SEL_LSB +: SEL_W];
      end
   end

   // R16 config layout
   assign cfg_read = {wd_off_flag, window_open_flag, CFG_RSVD, timeout_select_reg};

   // service register is write-only and reads zero, as does any unmapped address
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         reg_rdata <= RD_ZERO;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
         if (reg_rd) begin
            reg_rdata <= cfg_rd ? cfg_read : RD_ZERO;
         end
      end
   end

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (srst);

   // R16 reserved bits and select readback
   AST_CFG_LAYOUT: assert property ( // R16
      cfg_rd |=> reg_rvalid && reg_rdata[5:3] == CFG_RSVD
         && reg_rdata[2:0] == $past(timeout_select_reg))
      else $error("config read layout wrong");

   // R03 stop read shows off
   AST_STOP_OFF: assert property ( // R03
      cfg_rd && stop_mode |=> reg_rdata[BIT_OFF])
      else $error("stop-mode read lacks off bit");

   // R12 off bit follows disable
   AST_OFF_BIT: assert property ( // R12
      cfg_rd && dis_sync |=> reg_rdata[BIT_OFF] && !wd_reset)
      else $error("disabled state not shown");

   // R01 inactive outside normal mode
   AST_NORMAL_ONLY: assert property ( // R01
      !normal_mode |=> state_reg == ST_OFF && !wd_reset)
      else $error("watchdog running outside normal mode");

   // R05 window open during initial period
   AST_INIT_WO: assert property ( // R05
      state_reg == ST_INIT |-> window_open_flag)
      else $error("window-open clear in initial period");

   // R07 wrong initial code
   AST_WRONG_INIT: assert property ( // R07
      state_reg == ST_INIT && svc_wr && reg_wdata != SVC_FIRST
         |=> wd_reset ##1 !wd_reset && state_reg == ST_INIT)
      else $error("wrong initial code not reset");

   // R06 first code enters window mode
   AST_ENTER_WIN: assert property ( // R06
      state_reg == ST_INIT && svc_wr && reg_wdata == SVC_FIRST
         |=> state_reg == ST_WINDOW && expect_reg == SVC_SECOND && !wd_reset)
      else $error("window mode not entered");

   // R18 closed-window write
   AST_CLOSED_WR: assert property ( // R18
      state_reg == ST_WINDOW && svc_wr && cnt_reg < half_ticks |=> wd_reset)
      else $error("early service not reset");

   // R11 good service clears counter
   AST_GOOD_SVC: assert property ( // R11
      state_reg == ST_WINDOW && svc_wr && window_open_flag
         && reg_wdata == expect_reg
         |=> cnt_reg == CNT_ZERO && !wd_reset && expect_reg != $past(expect_reg))
      else $error("good service not taken");

   // R10 window expiry
   AST_TIMEOUT: assert property ( // R10
      state_reg == ST_WINDOW && tick && !svc_wr && cnt_inc == full_ticks
         |=> wd_reset && cnt_reg == CNT_ZERO)
      else $error("window expiry not reset");

   // R08 window half boundary
   AST_WO_HALF: assert property ( // R08
      state_reg == ST_WINDOW && $rose(window_open_flag)
         |-> cnt_reg == half_ticks)
      else $error("window opened off the half point");

   // R14 service writes ignored while disabled
   AST_DIS_IGNORE: assert property ( // R14
      !active |=> state_reg == ST_OFF && expect_reg == SVC_RST && !wd_reset)
      else $error("disabled watchdog reacted");

   // R02 counter never passes window unless the select is lowered mid-window
   AST_CNT_BOUND: assert property ( // R02
      state_reg == ST_WINDOW |-> cnt_reg < full_ticks)
      else $error("counter beyond window");

   // R07 initial expiry reset
   AST_INIT_EXPIRY: assert property ( // R07
      state_reg == ST_INIT && tick && !svc_wr && cnt_inc == INIT_TICKS |=> wd_reset)
      else $error("initial timeout not reset");

   // R07 reset restarts initial sequence
   AST_RST_STATE: assert property ( // R07
      wd_reset |-> state_reg == ST_INIT && cnt_reg == CNT_ZERO && expect_reg == SVC_RST)
      else $error("reset left stale service state");

   // R09 window shown closed when off
   AST_WO_OFF: assert property ( // R09
      !active |=> !window_open_flag)
      else $error("window-open shown while off");

   COV_ENTER_WIN: cover property (
      state_reg == ST_INIT ##1 state_reg == ST_WINDOW);
   COV_GOOD_SVC: cover property (
      state_reg == ST_WINDOW && svc_wr && window_open_flag ##1 !wd_reset);
   COV_TIMEOUT_RST: cover property (
      state_reg == ST_WINDOW && tick && cnt_inc == full_ticks ##1 wd_reset);
   COV_DISABLE: cover property (
      state_reg == ST_WINDOW ##1 dis_sync);
endmodule
`default_nettype wire

// File: tb/wdg_host.sv
// controller-side model: register strobes on the die link port
// assumes one process of the bench calls its tasks
`default_nettype none
module wdg_host import wdg_pkg::*; (
   input wire logic clk_sys, // base clock
   output logic reg_wr, // write strobe
   output logic reg_rd, // read strobe
   output logic [ADDR_W-1:0] reg_addr, // address
   output logic [7:0] reg_wdata, // write data
   input wire logic [7:0] reg_rdata, // read data
   input wire logic reg_rvalid // read valid
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] nxt_code;
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 16'h0000;
      reg_wdata = 8'h00;
      nxt_code = SVC_FIRST;
   end
   function automatic logic [ADDR_W-1:0] gaddr(input logic nb, input logic [ADDR_W-1:0] ofs);
      return (nb ? NB_BASE : BLK_BASE) + ofs;
   endfunction
   // released lines show the inverse so stale values never look valid
   task automatic wr(input logic nb, input logic [ADDR_W-1:0] ofs, input logic [7:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= gaddr(nb, ofs);
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      reg_addr <= ~gaddr(nb, ofs);
      reg_wdata <= ~d;
   endtask
   task automatic rd(input logic nb, input logic [ADDR_W-1:0] ofs, output logic [7:0] d);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= gaddr(nb, ofs);
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      reg_addr <= ~gaddr(nb, ofs);
      #1;
      d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hXX;
   endtask
   task automatic svc(input logic nb);
      wr(nb, OFS_SERVICE, nxt_code);
      nxt_code = ~nxt_code;
   endtask
   task automatic restart();
      nxt_code = SVC_FIRST;
   endtask
endmodule
`default_nettype wire

// File: tb/testbench.sv
// self-checking bench for the window watchdog core
// assumes a shortened tick of T cycles; the host model drives the bus
`default_nettype none
module testbench import wdg_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int T = 10;
   logic clk_sys, srst, normal_mode, stop_mode, tdv;
   logic reg_wr, reg_rd, reg_rvalid, wd_reset;
   logic [ADDR_W-1:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, d;
   logic [31:0] lfsr_q, w;
   int err_total, compares, cyc, rst_cnt, rst_cyc, mdl_sel, n0, st, h, f;
   wdg_core #(.TICK_CYCLES(T)) wdg_core_i (.clk_sys(clk_sys), .srst(srst),
      .normal_mode(normal_mode), .stop_mode(stop_mode), .test_disable_voltage(tdv),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .wd_reset(wd_reset));
   wdg_host wdg_host_i (.clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid));
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   // counting on the falling edge keeps cyc and rst_cnt clear of races
   // with the stimulus process, which wakes on the rising edge
   always @(negedge clk_sys) begin
      cyc++;
      if (wd_reset === 1'b1) begin
         rst_cnt++;
         rst_cyc = cyc;
      end
   end
   function automatic logic rb();
      lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
      return lfsr_q[5];
   endfunction
   // model of the config read-back
   function automatic logic [7:0] exp_cfg(input logic off, input logic wo);
      return {off, wo, CFG_RSVD, mdl_sel[2:0]};
   endfunction
   task automatic bad(input logic [31:0] got, input logic [31:0] exp);
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
   endtask
   task automatic rdchk(input logic nb, input logic [ADDR_W-1:0] ofs, input logic [7:0] exp);
      wdg_host_i.rd(nb, ofs, d);
      compares++;
      if (d !== exp) bad(d, exp);
   endtask
   task automatic complete_run();
      $display("compares=%0d err_total=%0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // bounded wait for a reset pulse, then its cycle offset is checked
   task automatic wait_rst(input int c0, input int s0, input int lo, input int hi);
      for (int i = 0; i < hi + 8 && rst_cnt == c0; i++) @(posedge clk_sys);
      compares++;
      if (rst_cnt == c0) begin
         bad(0, 1);
         complete_run();
      end
      if (rst_cyc - s0 < lo || rst_cyc - s0 > hi) bad(rst_cyc - s0, lo);
      wdg_host_i.restart();
   endtask
   task automatic no_rst(input int c0, input int n);
      repeat (n) @(posedge clk_sys);
      compares++;
      if (rst_cnt != c0) bad(rst_cnt, c0);
   endtask
   initial begin
      srst = 1'b1;
      normal_mode = 1'b1;
      stop_mode = 1'b0;
      tdv = 1'b0;
      lfsr_q = 32'h347D;
      err_total = 0;
      compares = 0;
      mdl_sel = 0;
      repeat (8) @(posedge clk_sys);
      srst <= 1'b0;
      n0 = rst_cnt;
      st = cyc;
      rdchk(1'b0, OFS_CONFIG, exp_cfg(1'b0, 1'b1));
      rdchk(1'b1, OFS_CONFIG, exp_cfg(1'b0, 1'b1));
      rdchk(rb(), 16'h0012, RD_ZERO);
      rdchk(rb(), OFS_SERVICE, RD_ZERO);
      wdg_host_i.wr(rb(), 16'h0012, 8'h07);
      wdg_host_i.wr(rb(), OFS_CONFIG, 8'hFF);
      mdl_sel = 7;
      rdchk(rb(), OFS_CONFIG, exp_cfg(1'b0, 1'b1));
      wait_rst(n0, st, 20 * T - 3, 20 * T + 5);
      $display("test initial timeout done");
      w = lfsr_q ^ 32'h5A;
      d = (w[7:0] == SVC_FIRST) ? 8'h00 : w[7:0];
      n0 = rst_cnt;
      st = cyc;
      wdg_host_i.wr(rb(), OFS_SERVICE, d);
      wait_rst(n0, st, 1, 5);
      $display("test initial wrong code done");
      for (int s = 0; s < 8; s++) begin
         h = 1 << s;
         f = 2 << s;
         mdl_sel = s;
         wdg_host_i.wr(rb(), OFS_CONFIG, 8'(s));
         wdg_host_i.svc(rb());
         repeat (h * T - 5) @(posedge clk_sys);
         rdchk(rb(), OFS_CONFIG, exp_cfg(1'b0, 1'b0));
         repeat (8) @(posedge clk_sys);
         rdchk(rb(), OFS_CONFIG, exp_cfg(1'b0, 1'b1));
         n0 = rst_cnt;
         st = cyc;
         wdg_host_i.svc(rb());
         case (s % 3)
            0: wait_rst(n0, st, f * T - 3, f * T + 5);
            1: begin
               n0 = rst_cnt;
               st = cyc;
               wdg_host_i.svc(rb());
               wait_rst(n0, st, 1, 5);
            end
            default: begin
               repeat (h * T + 4) @(posedge clk_sys);
               n0 = rst_cnt;
               st = cyc;
               wdg_host_i.wr(rb(), OFS_SERVICE, SVC_SECOND);
               wait_rst(n0, st, 1, 5);
            end
         endcase
         $display("test window select %0d done", s);
      end
      tdv <= 1'b1;
      repeat (5) @(posedge clk_sys);
      rdchk(rb(), OFS_CONFIG, exp_cfg(1'b1, 1'b0));
      n0 = rst_cnt;
      wdg_host_i.svc(rb());
      no_rst(n0, 20 * T + 20);
      tdv <= 1'b0;
      repeat (5) @(posedge clk_sys);
      rdchk(rb(), OFS_CONFIG, exp_cfg(1'b0, 1'b1));
      n0 = rst_cnt;
      st = cyc;
      wdg_host_i.wr(rb(), OFS_SERVICE, SVC_SECOND);
      wait_rst(n0, st, 1, 5);
      $display("test debug disable done");
      normal_mode <= 1'b0;
      stop_mode <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rdchk(rb(), OFS_CONFIG, exp_cfg(1'b1, 1'b0));
      n0 = rst_cnt;
      wdg_host_i.wr(rb(), OFS_SERVICE, SVC_FIRST);
      no_rst(n0, 300);
      normal_mode <= 1'b1;
      stop_mode <= 1'b0;
      repeat (3) @(posedge clk_sys);
      n0 = rst_cnt;
      st = cyc;
      wdg_host_i.wr(rb(), OFS_SERVICE, SVC_SECOND);
      wait_rst(n0, st, 1, 5);
      $display("test low power done");
      complete_run();
   end
endmodule
`default_nettype wire
